// ---- swk_pkg.sv ----
package swk_pkg;

  // Register offsets of the wake configuration block.
  localparam logic [7:0] OFS_CTRL     = 8'h20;
  localparam logic [7:0] OFS_BTIME    = 8'h21;
  localparam logic [7:0] OFS_SPOINT   = 8'h22;
  localparam logic [7:0] OFS_ID3      = 8'h23;
  localparam logic [7:0] OFS_ID2      = 8'h24;
  localparam logic [7:0] OFS_ID1      = 8'h25;
  localparam logic [7:0] OFS_ID0      = 8'h26;
  localparam logic [7:0] OFS_MASK3    = 8'h27;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h41;
  localparam logic [7:0] OFS_OPT      = 8'h42;

  // Reset values.
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_BTIME  = 8'ha0;
  localparam logic [5:0] RST_SPOINT = 6'h33;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // Control register field positions.
  localparam int CTRL_CAL     = 7;
  localparam int CTRL_TRIM_HI = 6;
  localparam int CTRL_TRIM_LO = 5;
  localparam int CTRL_TO_MASK = 4;
  localparam int CTRL_VALID   = 0;
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;

  // Lowest identifier register field positions.
  localparam int ID0_ID_HI = 6;
  localparam int ID0_ID_LO = 2;
  localparam int ID0_RTR   = 1;
  localparam int ID0_IDE   = 0;

  // Interrupt status bit positions.
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE    = 1;
  localparam int IRQ_MATCH   = 2;
  localparam int IRQ_W       = 3;

  // Standard identifier sits in identifier bits 28..18.
  localparam int STD_ID_LSB = 18;

endpackage

// ---- swk_id_match.sv ----
`timescale 1ns/1ps
// Compares a received frame header against the configured wake filter.
module swk_id_match (
  // Configured filter.
  input  wire logic [28:0] cfg_ident,
  input  wire logic [7:0]  cfg_mask_hi,
  input  wire logic        cfg_ext,
  input  wire logic        cfg_remote,
  // Received header.
  input  wire logic [28:0] rx_ident,
  input  wire logic        rx_ext,
  input  wire logic        rx_remote,
  // Result.
  output logic             hit
);

  logic [28:0] care;
  logic [28:0] diff;

  // Only the top identifier byte has a mask here; the lower bits have no mask.
  // A standard frame compares only bits 28..18.
  always_comb begin
    care = {cfg_mask_hi, 21'h1fffff};
    if (!cfg_ext) begin
      care[swk_pkg::STD_ID_LSB-1:0] = '0;
    end
    diff = (cfg_ident ^ rx_ident) & care;
    hit  = (diff == '0) && (rx_ext == cfg_ext) && (rx_remote == cfg_remote);
  end

endmodule

// ---- swk_wake_cfg.sv ----
`timescale 1ns/1ps
// What this block does
// - Bit 7 enables oscillator calibration.
// - Calibration unlocks only with trim field 11.
// - Calibration syncs oscillator to transmit pin.
// - Option register writable only when unlocked.
// - Timeout mask bit gates timeout interrupt.
// - Timeout flag updates only while wake active.
// - Selective wake requires valid bit set.
// - Valid clears on wake, reset, config write.
// - Reserved bits read as zero.
// - Bit time quanta register, reset a0.
// - Sample point fraction, reset 33.
// - Identifier spread over four registers.
// - Remote bit selects remote frame; host avoids.
// - Extension bit selects 11 or 29 bits.
// - Mask bit one compares, zero ignores.
module swk_wake_cfg (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Mode and events from the transceiver core.
  input  wire logic        swk_mode_active,
  input  wire logic        bus_timeout_evt,
  input  wire logic        frame_rx_valid,
  input  wire logic [28:0] frame_rx_ident,
  input  wire logic        frame_rx_ext,
  input  wire logic        frame_rx_remote,
  // Pins.
  input  wire logic        bus_transmit_input_pin,
  output logic             interrupt_out_pin,
  // Configuration towards the wake core.
  output logic             swk_enable,
  output logic             wake_up_frame_seen,
  output logic             osc_calibration_on,
  output logic             osc_ref_sample,
  output logic      [7:0]  bit_time_quanta,
  output logic      [5:0]  sample_point_pos,
  output logic      [7:0]  rx_option
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic        cal_r;
  logic [1:0]  trim_r;
  logic        to_en_r;
  logic        valid_r;
  logic [7:0]  btime_r;
  logic [5:0]  spoint_r;
  logic [7:0]  id3_r;
  logic [7:0]  id2_r;
  logic [7:0]  id1_r;
  logic [4:0]  id0_r;
  logic        rtr_r;
  logic        ide_r;
  logic [7:0]  mask3_r;
  logic [7:0]  opt_r;
  logic [swk_pkg::IRQ_W-1:0] stat_r;
  logic [swk_pkg::IRQ_W-1:0] imask_r;
  logic        timeout_flag_r;
  logic        tx_sync1_r;
  logic        tx_sync2_r;
  logic        hit;
  logic        wake_evt;
  logic        unlocked;
  logic        cfg_write;
  logic        wr_ctrl;
  logic        rd_stat;
  logic [swk_pkg::IRQ_W-1:0] evt;

  assign unlocked  = (trim_r == swk_pkg::TRIM_UNLOCK);
  assign wr_ctrl   = reg_wr && (reg_addr == swk_pkg::OFS_CTRL);
  assign rd_stat   = reg_rd && (reg_addr == swk_pkg::OFS_IRQ_STAT);

  // Any write to the filter or timing registers invalidates the setup.
  assign cfg_write = reg_wr && (reg_addr >= swk_pkg::OFS_BTIME)
                     && (reg_addr <= swk_pkg::OFS_MASK3);

  ////////////////////////////////////////////////////////////////////////////
  // Wake filter compare.
  swk_id_match u_match (
    .cfg_ident   ({id3_r, id2_r, id1_r, id0_r}),
    .cfg_mask_hi (mask3_r),
    .cfg_ext     (ide_r),
    .cfg_remote  (rtr_r),
    .rx_ident    (frame_rx_ident),
    .rx_ext      (frame_rx_ext),
    .rx_remote   (frame_rx_remote),
    .hit         (hit)
  );

  // A frame wakes only when the setup is validated and wake mode runs.
  assign wake_evt = frame_rx_valid && hit && valid_r && swk_mode_active;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_r   <= swk_pkg::RST_CTRL[swk_pkg::CTRL_CAL];
      trim_r  <= swk_pkg::RST_CTRL[swk_pkg::CTRL_TRIM_HI:swk_pkg::CTRL_TRIM_LO];
      to_en_r <= swk_pkg::RST_CTRL[swk_pkg::CTRL_TO_MASK];
    end else if (wr_ctrl) begin
      cal_r   <= reg_wdata[swk_pkg::CTRL_CAL];
      trim_r  <= reg_wdata[swk_pkg::CTRL_TRIM_HI:swk_pkg::CTRL_TRIM_LO];
      to_en_r <= reg_wdata[swk_pkg::CTRL_TO_MASK];
    end
  end

  // Valid bit: reset and wake clear it, a filter write clears it, host sets it.
  // The hardware clear wins so a stale setup can never stay armed.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valid_r <= swk_pkg::RST_CTRL[swk_pkg::CTRL_VALID];
    end else if (wake_evt || cfg_write) begin
      valid_r <= 1'b0;
    end else if (wr_ctrl) begin
      valid_r <= reg_wdata[swk_pkg::CTRL_VALID];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing and filter registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      btime_r  <= swk_pkg::RST_BTIME;
      spoint_r <= swk_pkg::RST_SPOINT;
      id3_r    <= swk_pkg::RST_ZERO;
      id2_r    <= swk_pkg::RST_ZERO;
      id1_r    <= swk_pkg::RST_ZERO;
      id0_r    <= swk_pkg::RST_ZERO[4:0];
      rtr_r    <= 1'b0;
      ide_r    <= 1'b0;
      mask3_r  <= swk_pkg::RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        swk_pkg::OFS_BTIME:  btime_r  <= reg_wdata;
        swk_pkg::OFS_SPOINT: spoint_r <= reg_wdata[5:0];
        swk_pkg::OFS_ID3:    id3_r    <= reg_wdata;
        swk_pkg::OFS_ID2:    id2_r    <= reg_wdata;
        swk_pkg::OFS_ID1:    id1_r    <= reg_wdata;
        swk_pkg::OFS_ID0: begin
          id0_r <= reg_wdata[swk_pkg::ID0_ID_HI:swk_pkg::ID0_ID_LO];
          rtr_r <= reg_wdata[swk_pkg::ID0_RTR];
          ide_r <= reg_wdata[swk_pkg::ID0_IDE];
        end
        swk_pkg::OFS_MASK3:  mask3_r  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Receiver option register: locked unless the trim field holds the key.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opt_r <= swk_pkg::RST_ZERO;
    end else if (reg_wr && (reg_addr == swk_pkg::OFS_OPT) && unlocked) begin
      opt_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus timeout flag, frozen outside wake mode.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timeout_flag_r <= 1'b0;
    end else if (swk_mode_active) begin
      timeout_flag_r <= bus_timeout_evt;
    end
  end

  // Events: timeout (gated by its own enable), wake, and raw filter hit.
  assign evt[swk_pkg::IRQ_TIMEOUT] = bus_timeout_evt && swk_mode_active && to_en_r;
  assign evt[swk_pkg::IRQ_WAKE]    = wake_evt;
  assign evt[swk_pkg::IRQ_MATCH]   = frame_rx_valid && hit;

  // Sticky status; a read clears, but a same-cycle event stays set.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_r <= '0;
    end else if (rd_stat) begin
      stat_r <= evt;
    end else begin
      stat_r <= stat_r | evt;
    end
  end

  // Interrupt mask, one bit for each status bit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      imask_r <= '0;
    end else if (reg_wr && (reg_addr == swk_pkg::OFS_IRQ_MASK)) begin
      imask_r <= reg_wdata[swk_pkg::IRQ_W-1:0];
    end
  end

  // Output registered from next status so the pin tracks status exactly.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_out_pin <= 1'b0;
    end else begin
      interrupt_out_pin <= |((rd_stat ? evt : (stat_r | evt)) & imask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pin reference for oscillator trimming; two flops before use.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_sync1_r <= 1'b0;
      tx_sync2_r <= 1'b0;
    end else begin
      tx_sync1_r <= bus_transmit_input_pin;
      tx_sync2_r <= tx_sync1_r;
    end
  end

  // Calibration runs only when enabled and unlocked; reference idles high.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_calibration_on <= 1'b0;
      osc_ref_sample     <= 1'b1;
    end else begin
      osc_calibration_on <= cal_r && unlocked;
      osc_ref_sample     <= (cal_r && unlocked) ? tx_sync2_r : 1'b1;
    end
  end

  // Configuration outputs to the wake core.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      swk_enable         <= 1'b0;
      wake_up_frame_seen <= 1'b0;
      bit_time_quanta    <= swk_pkg::RST_BTIME;
      sample_point_pos   <= swk_pkg::RST_SPOINT;
      rx_option          <= swk_pkg::RST_ZERO;
    end else begin
      swk_enable         <= valid_r && !(wake_evt || cfg_write);
      wake_up_frame_seen <= wake_evt;
      bit_time_quanta    <= btime_r;
      sample_point_pos   <= spoint_r;
      rx_option          <= opt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; reserved bits are zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        swk_pkg::OFS_CTRL:     reg_rdata <= {cal_r, trim_r, to_en_r, 3'h0, valid_r};
        swk_pkg::OFS_BTIME:    reg_rdata <= btime_r;
        swk_pkg::OFS_SPOINT:   reg_rdata <= {2'h0, spoint_r};
        swk_pkg::OFS_ID3:      reg_rdata <= id3_r;
        swk_pkg::OFS_ID2:      reg_rdata <= id2_r;
        swk_pkg::OFS_ID1:      reg_rdata <= id1_r;
        swk_pkg::OFS_ID0:      reg_rdata <= {1'b0, id0_r, rtr_r, ide_r};
        swk_pkg::OFS_MASK3:    reg_rdata <= mask3_r;
        swk_pkg::OFS_IRQ_STAT: reg_rdata <= {4'h0, timeout_flag_r, stat_r};
        swk_pkg::OFS_IRQ_MASK: reg_rdata <= {5'h0, imask_r};
        swk_pkg::OFS_OPT:      reg_rdata <= opt_r;
        default:               reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // All but the reset check are disabled in reset, so they see only settled values.
  a_valid_clear_cfg: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_write |=> !valid_r)
    else $error("valid bit survived a filter write");

  a_valid_clear_wake: assert property (@(posedge clk_sys) disable iff (rst)
    wake_evt |=> !valid_r && wake_up_frame_seen)
    else $error("valid bit survived a wake");

  a_wake_needs_valid: assert property (@(posedge clk_sys) disable iff (rst)
    wake_up_frame_seen |-> $past(valid_r))
    else $error("wake without valid setup");

  a_opt_locked: assert property (@(posedge clk_sys) disable iff (rst)
    !unlocked |=> $stable(opt_r))
    else $error("option register changed while locked");

  a_cal_unlock: assert property (@(posedge clk_sys) disable iff (rst)
    osc_calibration_on |-> $past(trim_r) == swk_pkg::TRIM_UNLOCK && $past(cal_r))
    else $error("calibration on without unlock");

  a_cal_ref_pin: assert property (@(posedge clk_sys) disable iff (rst)
    (cal_r && unlocked) |=> osc_ref_sample == $past(tx_sync2_r))
    else $error("reference does not follow pin");

  a_timeout_masked: assert property (@(posedge clk_sys) disable iff (rst)
    (!to_en_r && !rd_stat) |=>
      stat_r[swk_pkg::IRQ_TIMEOUT] == $past(stat_r[swk_pkg::IRQ_TIMEOUT]))
    else $error("masked timeout set status");

  a_timeout_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    !swk_mode_active |=> $stable(timeout_flag_r))
    else $error("timeout flag moved outside wake mode");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == swk_pkg::OFS_CTRL |=> reg_rdata[3:1] == 3'h0)
    else $error("reserved control bits not zero");

  a_btime_reset: assert property (@(posedge clk_sys)
    $past(rst) |-> btime_r == swk_pkg::RST_BTIME && spoint_r == swk_pkg::RST_SPOINT)
    else $error("timing reset value wrong");

  // The pin is registered from the next status, so it pairs with last cycle's mask.
  a_irq_pin_level: assert property (@(posedge clk_sys) disable iff (rst)
    interrupt_out_pin == |(stat_r & $past(imask_r)))
    else $error("interrupt pin disagrees with masked status");

  a_opt_open: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == swk_pkg::OFS_OPT && unlocked) |=> opt_r == $past(reg_wdata))
    else $error("unlocked option write lost");

  a_cal_follow: assert property (@(posedge clk_sys) disable iff (rst)
    osc_calibration_on == $past(cal_r && unlocked))
    else $error("calibration output does not follow its bit");

  a_valid_host_set: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ctrl && reg_wdata[swk_pkg::CTRL_VALID] && !wake_evt) |=> valid_r)
    else $error("host could not set the valid bit");

  a_timeout_follow: assert property (@(posedge clk_sys) disable iff (rst)
    swk_mode_active |=> timeout_flag_r == $past(bus_timeout_evt))
    else $error("timeout flag missed the event in wake mode");

  a_rsvd_ident: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == swk_pkg::OFS_ID0) |=> !reg_rdata[swk_pkg::ID0_ID_HI+1])
    else $error("reserved identifier bit not zero");

  // A wake clears the valid bit, so a second wake needs a fresh host set.
  a_wake_single: assert property (@(posedge clk_sys) disable iff (rst)
    wake_up_frame_seen |=> !wake_up_frame_seen)
    else $error("wake pulse longer than one cycle");

endmodule

// ---- swk_frame_src.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Remote bus node that hands received wake-frame headers to the block.
module swk_frame_src (
  // Clock.
  input  wire logic        clk_sys,
  // Received header.
  output logic             frame_rx_valid,
  output logic      [28:0] frame_rx_ident,
  output logic             frame_rx_ext,
  output logic             frame_rx_remote
);
  // Quiet lines at start.
  initial begin
    frame_rx_valid  = 1'b0;
    frame_rx_ident  = 29'h0;
    frame_rx_ext    = 1'b0;
    frame_rx_remote = 1'b0;
  end
  // One header per call; afterwards the lines show the inverse so that a
  // stale header can never pass for a fresh one.
  task automatic send(input logic [28:0] id, input logic ext, input logic rem);
    @(posedge clk_sys);
    frame_rx_valid  <= 1'b1;
    frame_rx_ident  <= id;
    frame_rx_ext    <= ext;
    frame_rx_remote <= rem;
    @(posedge clk_sys);
    frame_rx_valid  <= 1'b0;
    frame_rx_ident  <= ~id;
    frame_rx_ext    <= ~ext;
    frame_rx_remote <= ~rem;
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic              clk_sys, rst, reg_wr, reg_rd, mode, tmo_evt, tx_pin;
  logic       [7:0]  reg_addr, reg_wdata, reg_rdata, btq, ropt;
  logic       [5:0]  spp;
  logic              irq, swk_en, seen, cal_on, ref_s, f_vld, f_ext, f_rem;
  logic       [28:0] f_id;
  int                errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  // Standard identifier placed in bits 28..18.
  localparam logic [28:0] WID = {11'h5a3, 18'h0};
  // Free-running clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  swk_wake_cfg swk_wake_cfg_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .swk_mode_active(mode), .bus_timeout_evt(tmo_evt), .frame_rx_valid(f_vld),
    .frame_rx_ident(f_id), .frame_rx_ext(f_ext), .frame_rx_remote(f_rem),
    .bus_transmit_input_pin(tx_pin), .interrupt_out_pin(irq), .swk_enable(swk_en),
    .wake_up_frame_seen(seen), .osc_calibration_on(cal_on), .osc_ref_sample(ref_s),
    .bit_time_quanta(btq), .sample_point_pos(spp), .rx_option(ropt));
  swk_frame_src swk_frame_src_i (.clk_sys(clk_sys), .frame_rx_valid(f_vld),
    .frame_rx_ident(f_id), .frame_rx_ext(f_ext), .frame_rx_remote(f_rem));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared comparison and bus tasks.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic frame(input logic [28:0] id, input logic ext, rem, input logic e);
    swk_frame_src_i.send(id, ext, rem);
    #1 chk("wake seen", {7'h0, e}, {7'h0, seen});
  endtask
  // A one-cycle time-out event, then time for status and pin to settle.
  task automatic pulse;
    tmo_evt <= 1'b1;
    @(posedge clk_sys);
    tmo_evt <= 1'b0;
    idle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ex [8] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(8'(swk_pkg::OFS_CTRL + i), ex[i], "reset value");
    end
    rd(8'h30, 8'h00, "unmapped");
    chk("quanta out", 8'ha0, btq);
    chk("sample out", 8'h33, {2'b00, spp});
    $display("test reset done");
  endtask
  task automatic t_fields;
    wr(swk_pkg::OFS_SPOINT, 8'hff);
    rd(swk_pkg::OFS_SPOINT, 8'h3f, "sample point");
    chk("sample out", 8'h3f, {2'b00, spp});
    wr(swk_pkg::OFS_ID0, 8'hff);
    rd(swk_pkg::OFS_ID0, 8'h7f, "ident low");
    wr(swk_pkg::OFS_BTIME, 8'h5c);
    rd(swk_pkg::OFS_BTIME, 8'h5c, "bit time");
    chk("quanta out", 8'h5c, btq);
    wr(swk_pkg::OFS_CTRL, 8'h1e);
    rd(swk_pkg::OFS_CTRL, 8'h10, "control");
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00, "unmapped");
    $display("test fields done");
  endtask
  // Every combination of calibration bit and trim field.
  task automatic t_calib;
    for (int i = 0; i < 8; i++) begin
      wr(swk_pkg::OFS_CTRL, {i[2:0], 5'h00});
      idle(2);
      chk("calibration", {7'h0, i == 7}, {7'h0, cal_on});
    end
    @(posedge clk_sys);
    tx_pin <= 1'b0;
    idle(4);
    chk("ref sample", 8'h00, {7'h0, ref_s});
    @(posedge clk_sys);
    tx_pin <= 1'b1;
    idle(4);
    chk("ref sample", 8'h01, {7'h0, ref_s});
    wr(swk_pkg::OFS_CTRL, 8'h40);
    tx_pin <= 1'b0;
    wr(swk_pkg::OFS_OPT, 8'h5a);
    idle(4);
    chk("ref idle", 8'h01, {7'h0, ref_s});
    rd(swk_pkg::OFS_OPT, 8'h00, "option locked");
    wr(swk_pkg::OFS_CTRL, 8'h60);
    wr(swk_pkg::OFS_OPT, 8'h5a);
    rd(swk_pkg::OFS_OPT, 8'h5a, "option open");
    chk("option out", 8'h5a, ropt);
    @(posedge clk_sys);
    tx_pin <= 1'b1;
    $display("test calib done");
  endtask
  task automatic t_wake;
    wr(swk_pkg::OFS_ID3, WID[28:21]);
    wr(swk_pkg::OFS_ID2, WID[20:13]);
    wr(swk_pkg::OFS_ID1, WID[12:5]);
    wr(swk_pkg::OFS_ID0, {1'b0, WID[4:0], 2'b00});
    wr(swk_pkg::OFS_MASK3, 8'hff);
    mode <= 1'b1;
    wr(swk_pkg::OFS_CTRL, 8'h01);
    idle(2);
    chk("enable", 8'h01, {7'h0, swk_en});
    wr(swk_pkg::OFS_BTIME, 8'ha0);
    idle(2);
    chk("enable", 8'h00, {7'h0, swk_en});
    rd(swk_pkg::OFS_CTRL, 8'h00, "valid after edit");
    wr(swk_pkg::OFS_CTRL, 8'h01);
    frame(WID ^ 29'h10000000, 1'b0, 1'b0, 1'b0);
    frame(WID, 1'b1, 1'b0, 1'b0);
    frame(WID, 1'b0, 1'b1, 1'b0);
    frame(WID | 29'h3ffff, 1'b0, 1'b0, 1'b1);
    idle(1);
    chk("enable", 8'h00, {7'h0, swk_en});
    rd(swk_pkg::OFS_CTRL, 8'h00, "valid after wake");
    frame(WID, 1'b0, 1'b0, 1'b0);
    wr(swk_pkg::OFS_MASK3, 8'h00);
    wr(swk_pkg::OFS_CTRL, 8'h01);
    frame(WID ^ 29'h1fe00000, 1'b0, 1'b0, 1'b1);
    $display("test wake done");
  endtask
  task automatic t_irq;
    rd(swk_pkg::OFS_IRQ_STAT, 8'h06, "wake status");
    rd(swk_pkg::OFS_IRQ_STAT, 8'h00, "status cleared");
    wr(swk_pkg::OFS_CTRL, 8'h10);
    wr(swk_pkg::OFS_IRQ_MASK, 8'h01);
    pulse();
    chk("irq pin", 8'h01, {7'h0, irq});
    rd(swk_pkg::OFS_IRQ_STAT, 8'h01, "timeout status");
    idle(2);
    chk("irq pin", 8'h00, {7'h0, irq});
    wr(swk_pkg::OFS_IRQ_MASK, 8'h00);
    pulse();
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(swk_pkg::OFS_IRQ_STAT, 8'h01, "masked status");
    wr(swk_pkg::OFS_CTRL, 8'h00);
    wr(swk_pkg::OFS_IRQ_MASK, 8'h01);
    pulse();
    chk("irq off", 8'h00, {7'h0, irq});
    rd(swk_pkg::OFS_IRQ_STAT, 8'h00, "timeout off");
    wr(swk_pkg::OFS_CTRL, 8'h10);
    mode    <= 1'b0;
    tmo_evt <= 1'b1;
    idle(3);
    rd(swk_pkg::OFS_IRQ_STAT, 8'h00, "mode idle");
    chk("irq idle", 8'h00, {7'h0, irq});
    @(posedge clk_sys);
    mode <= 1'b1;
    idle(3);
    rd(swk_pkg::OFS_IRQ_STAT, 8'h09, "mode on");
    @(posedge clk_sys);
    tmo_evt <= 1'b0;
    $display("test irq done");
  endtask
  // A reset in mid-run must drop an armed setup and restore the sample point field.
  task automatic t_restart;
    wr(swk_pkg::OFS_CTRL, 8'h11);
    idle(1);
    chk("enable armed", 8'h01, {7'h0, swk_en});
    chk("irq held", 8'h01, {7'h0, irq});
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(swk_pkg::OFS_CTRL, 8'h00, "valid after reset");
    rd(swk_pkg::OFS_SPOINT, 8'h33, "sample after reset");
    chk("enable reset", 8'h00, {7'h0, swk_en});
    chk("irq reset", 8'h00, {7'h0, irq});
    // A matching frame outside wake mode must not wake nor disarm the setup.
    wr(swk_pkg::OFS_CTRL, 8'h01);
    mode <= 1'b0;
    frame(29'h0, 1'b0, 1'b0, 1'b0);
    @(posedge clk_sys);
    mode <= 1'b1;
    frame(29'h0, 1'b0, 1'b0, 1'b1);
    $display("test restart done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // Main sequence.
  initial begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    mode      = 1'b0;
    tmo_evt   = 1'b0;
    tx_pin    = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_calib();
    t_wake();
    t_irq();
    t_restart();
    give_verdict();
  end
endmodule
